// ===== rtl/can_rx_buffer1_control.sv
// Receive buffer 1 control register, acceptance and interrupt logic
//
// The implementer's own choices: the address map and register access over APB.
`timescale 1ns/1ns
`default_nettype none
`include "can_rx_consts.svh"

module can_rx_buffer1_control #(
  parameter int ADDR_W = 8, // APB address width
  parameter int DATA_W = 32 // APB data width
) (
  input wire logic clock, // System clock
  input wire logic rst, // Synchronous reset, active high
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction, high for write
  input wire logic [ADDR_W-1:0] paddr, // APB byte address
  input wire logic [DATA_W-1:0] pwdata, // APB write data
  output logic [DATA_W-1:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic msgValid, // Engine offers a message, one cycle
  input wire logic msgError, // Offered message has errors
  input wire logic msgExtended, // Offered message is extended id
  input wire logic msgRemote, // Offered message is remote request
  input wire can_rx_pkg::filter_index_type msgFilter, // Hit filter
  input wire logic doubleBufferEnable, // Buffer 0 overflow enable
  output logic msgLoad, // Store the offered message, one cycle
  output logic rxBufferFullFlag, // Buffer 1 holds a message
  output can_rx_pkg::accept_mode_type rxAcceptMode, // Mode field
  output logic irq // Level interrupt
);
  import can_rx_pkg::*;

  // ==========================================================
  // Elaboration checks
  if (ADDR_W < 8) begin : g_addr_check
    $error("ADDR_W too small for the register map");
  end
  if (DATA_W < 8) begin : g_data_check
    $error("DATA_W must hold the 8-bit control register");
  end

  // ==========================================================
  // Declarations
  logic fullR;
  accept_mode_type modeR;
  logic remoteR;
  filter_index_type hitR;
  logic [`CRX_EV_W-1:0] statusR;
  logic [`CRX_EV_W-1:0] statusNxt;
  logic [`CRX_EV_W-1:0] enableR;
  logic [`CRX_EV_W-1:0] events;
  logic [DATA_W-1:0] prdataR;
  logic [DATA_W-1:0] readMux;
  logic slvErrR;
  logic irqR;
  logic admit;
  logic setupPhase;
  logic accessPhase;
  logic wrCtrl;
  logic wrClear;
  logic wrEnable;
  logic [7:0] ctrlView;

  // ==========================================================
  // Address decode
  function automatic logic isMapped(input logic [ADDR_W-1:0] addr);
    logic [7:0] a;
    a = addr[7:0];
    isMapped = (a == `CRX_OFF_CTRL) || (a == `CRX_OFF_STATUS) ||
               (a == `CRX_OFF_CLEAR) || (a == `CRX_OFF_ENABLE);
    if (ADDR_W > 8) begin
      isMapped = isMapped && (addr >> 8) == '0;
    end
  endfunction : isMapped

  function automatic logic hits(input logic [ADDR_W-1:0] addr,
                                input logic [7:0] off);
    hits = isMapped(addr) && addr[7:0] == off;
  endfunction : hits

  assign setupPhase = psel && !penable;
  assign accessPhase = psel && penable;
  assign wrCtrl = accessPhase && pwrite && hits(paddr, `CRX_OFF_CTRL);
  assign wrClear = accessPhase && pwrite && hits(paddr, `CRX_OFF_CLEAR);
  assign wrEnable = accessPhase && pwrite && hits(paddr, `CRX_OFF_ENABLE);

  // ==========================================================
  // Acceptance
  rx_accept_filter u_accept (
    .rxAcceptMode(modeR),
    .msgError(msgError),
    .msgExtended(msgExtended),
    .msgFilter(msgFilter),
    .doubleBufferEnable(doubleBufferEnable),
    .admit(admit)
  );

  // Only a free buffer takes a message
  assign msgLoad = msgValid && admit && !fullR;

  // ==========================================================
  // Full flag: hardware sets, a write of zero to bit 7 clears
  always_ff @(posedge clock) begin
    if (rst) begin
      fullR <= 1'b0;
    end else if (msgLoad) begin
      fullR <= 1'b1;
    end else if (wrCtrl && !pwdata[`CRX_FULL_BIT]) begin
      fullR <= 1'b0;
    end
  end

  // ==========================================================
  // Mode field
  always_ff @(posedge clock) begin
    if (rst) begin
      modeR <= MODE_VALID_ALL;
    end else if (wrCtrl) begin
      modeR <= accept_mode_type'(pwdata[`CRX_MODE_HI:`CRX_MODE_LO]);
    end
  end

  // ==========================================================
  // Message attributes, captured only on a load
  always_ff @(posedge clock) begin
    if (rst) begin
      remoteR <= 1'b0;
      hitR <= `CRX_HIT_RESET;
    end else if (msgLoad) begin
      remoteR <= msgRemote;
      hitR <= msgFilter;
    end
  end

  // ==========================================================
  // Interrupt status, enable and output
  assign events = {msgValid && fullR, msgLoad};

  // A new event wins over a clear in the same cycle
  always_comb begin
    statusNxt = statusR;
    if (wrClear) begin
      statusNxt = statusNxt & ~pwdata[`CRX_EV_W-1:0];
    end
    statusNxt = statusNxt | events;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      statusR <= `CRX_EV_RESET;
    end else begin
      statusR <= statusNxt;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      enableR <= `CRX_EV_RESET;
    end else if (wrEnable) begin
      enableR <= pwdata[`CRX_EV_W-1:0];
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      irqR <= 1'b0;
    end else begin
      irqR <= |(statusR & enableR);
    end
  end

  // ==========================================================
  // Read path, sampled in the setup phase
  always_comb begin
    ctrlView = `CRX_CTRL_RESET;
    ctrlView[`CRX_FULL_BIT] = fullR;
    ctrlView[`CRX_MODE_HI:`CRX_MODE_LO] = modeR;
    ctrlView[`CRX_GAP_BIT] = 1'b0;
    ctrlView[`CRX_RTR_BIT] = remoteR;
    ctrlView[`CRX_HIT_HI:`CRX_HIT_LO] = hitR;
  end

  always_comb begin
    readMux = '0;
    if (hits(paddr, `CRX_OFF_CTRL)) begin
      readMux[7:0] = ctrlView;
    end else if (hits(paddr, `CRX_OFF_STATUS)) begin
      readMux[`CRX_EV_W-1:0] = statusR;
    end else if (hits(paddr, `CRX_OFF_ENABLE)) begin
      readMux[`CRX_EV_W-1:0] = enableR;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      prdataR <= '0;
      slvErrR <= 1'b0;
    end else if (setupPhase) begin
      prdataR <= pwrite ? '0 : readMux;
      slvErrR <= !isMapped(paddr);
    end
  end

  // ==========================================================
  // Outputs
  assign prdata = prdataR;
  assign pready = accessPhase;
  assign pslverr = accessPhase && slvErrR;
  assign rxBufferFullFlag = fullR;
  assign rxAcceptMode = modeR;
  assign irq = irqR;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  a_load_sets_full: assert property (
    msgLoad |=> rxBufferFullFlag
  ) else $error("full flag not set after a load");

  a_full_blocks_load: assert property (
    rxBufferFullFlag |-> !msgLoad
  ) else $error("load while buffer full");

  a_free_takes_msg: assert property (
    (!rxBufferFullFlag && msgValid && admit) |-> msgLoad
  ) else $error("free buffer refused an admitted message");

  a_full_only_sw_clear: assert property (
    (rxBufferFullFlag && !(wrCtrl && !pwdata[`CRX_FULL_BIT]))
      |=> rxBufferFullFlag
  ) else $error("full flag cleared without a software write");

  a_mode_any_takes: assert property (
    (msgValid && !fullR && modeR == MODE_ANY &&
     msgFilter >= `CRX_HIT_DB_LIMIT &&
     msgFilter <= `CRX_HIT_MAX) |-> msgLoad
  ) else $error("mode 11 dropped a message");

  a_mode_ext_std: assert property (
    (msgLoad && (modeR == MODE_VALID_EXT || modeR == MODE_VALID_STD))
      |-> !msgError && (msgExtended == (modeR == MODE_VALID_EXT))
  ) else $error("identifier format mode violated");

  a_mode_valid_all: assert property (
    (msgLoad && modeR == MODE_VALID_ALL) |-> !msgError
  ) else $error("mode 00 loaded an erroneous message");

  a_bit4_reads_zero: assert property (
    (setupPhase && !pwrite && hits(paddr, `CRX_OFF_CTRL))
      |=> prdata[`CRX_GAP_BIT] == 1'b0 &&
          prdata[`CRX_FULL_BIT] == $past(fullR)
  ) else $error("control read returned wrong bits");

  a_remote_capture: assert property (
    msgLoad |=> remoteR == $past(msgRemote)
  ) else $error("remote flag not captured");

  a_hit_never_rsvd: assert property (
    hitR <= `CRX_HIT_MAX
  ) else $error("reserved filter code stored");

  a_hit_db_only: assert property (
    (msgLoad && msgFilter < `CRX_HIT_DB_LIMIT) |-> doubleBufferEnable
  ) else $error("filter 0 or 1 without double buffering");

  a_hit_encoding: assert property (
    msgLoad |=> hitR == $past(msgFilter)
  ) else $error("filter code differs from filter number");

  a_full_holds_data: assert property (
    rxBufferFullFlag |=> $stable(hitR) && $stable(remoteR)
  ) else $error("held message attributes overwritten");

  c_load: cover property (msgLoad ##1 rxBufferFullFlag);
  c_drop: cover property (msgValid && rxBufferFullFlag);
  c_release_reload: cover property (
    (wrCtrl && !pwdata[`CRX_FULL_BIT]) ##[1:20] msgLoad
  );
  c_irq: cover property ($rose(irq));

endmodule : can_rx_buffer1_control
`default_nettype wire

// ===== shared/can_rx_consts.svh
// Register offsets, field positions and reset values of receive buffer 1
`ifndef CAN_RX_CONSTS_SVH
`define CAN_RX_CONSTS_SVH

// ==========================================================
// Register byte offsets
`define CRX_OFF_CTRL 8'h00
`define CRX_OFF_STATUS 8'h04
`define CRX_OFF_CLEAR 8'h08
`define CRX_OFF_ENABLE 8'h0c

// ==========================================================
// Control register fields
`define CRX_FULL_BIT 7
`define CRX_MODE_HI 6
`define CRX_MODE_LO 5
`define CRX_GAP_BIT 4
`define CRX_RTR_BIT 3
`define CRX_HIT_HI 2
`define CRX_HIT_LO 0
`define CRX_CTRL_RESET 8'h00

// ==========================================================
// Event bits of status, clear and enable registers
`define CRX_EV_LOAD 0
`define CRX_EV_DROP 1
`define CRX_EV_W 2
`define CRX_EV_RESET 2'h0

// ==========================================================
// Filter codes
`define CRX_HIT_RESET 3'h0
`define CRX_HIT_MAX 3'h5
`define CRX_HIT_DB_LIMIT 3'h2

`endif

// ===== shared/can_rx_pkg.sv
// Types shared by the receive buffer 1 control logic
`default_nettype none
package can_rx_pkg;

  // ==========================================================
  // Acceptance modes
  typedef enum logic [1:0] {
    MODE_VALID_ALL = 2'b00,
    MODE_VALID_STD = 2'b01,
    MODE_VALID_EXT = 2'b10,
    MODE_ANY = 2'b11
  } accept_mode_type;

  typedef logic [2:0] filter_index_type;

endpackage : can_rx_pkg
`default_nettype wire

// ===== rtl/rx_accept_filter.sv
// Acceptance decision for one offered message into receive buffer 1
`timescale 1ns/1ns
`default_nettype none
`include "can_rx_consts.svh"

module rx_accept_filter (
  input wire can_rx_pkg::accept_mode_type rxAcceptMode, // Mode field
  input wire logic msgError, // Offered message has errors
  input wire logic msgExtended, // Offered message is extended id
  input wire can_rx_pkg::filter_index_type msgFilter, // Filter that hit
  input wire logic doubleBufferEnable, // Buffer 0 overflow enable
  output logic admit // Message may enter buffer 1
);
  import can_rx_pkg::*;

  logic modeOk;
  logic hitOk;

  // ==========================================================
  // Mode check
  always_comb begin
    unique case (rxAcceptMode)
      MODE_ANY: modeOk = 1'b1;
      MODE_VALID_EXT: modeOk = !msgError && msgExtended;
      MODE_VALID_STD: modeOk = !msgError && !msgExtended;
      MODE_VALID_ALL: modeOk = !msgError;
    endcase
  end

  // ==========================================================
  // Filter code check: reserved codes never stored, filters 0 and 1
  // only as overflow from buffer 0
  always_comb begin
    hitOk = (msgFilter <= `CRX_HIT_MAX);
    if (msgFilter < `CRX_HIT_DB_LIMIT) begin
      hitOk = doubleBufferEnable;
    end
  end

  assign admit = modeOk && hitOk;

endmodule : rx_accept_filter
`default_nettype wire

// ===== testbench/can_engine_model.sv
// Behavioural CAN engine that offers one message per request
`timescale 1ns/1ns
`default_nettype none

module can_engine_model (
  input wire logic clock, // System clock
  input wire logic rst, // Synchronous reset
  input wire logic sendReq, // Offer a message next cycle
  input wire logic [5:0] sendAttr, // Error, extended, remote, filter
  output logic msgValid = 1'b0, // Offer strobe, one cycle
  output logic msgError = 1'b0, // Message has errors
  output logic msgExtended = 1'b0, // Extended identifier
  output logic msgRemote = 1'b0, // Remote request
  output can_rx_pkg::filter_index_type msgFilter = 3'h0 // Filter hit
);
  import can_rx_pkg::*;
  // ==========================================================
  // Strobe
  always_ff @(posedge clock) begin
    if (rst) begin
      msgValid <= 1'b0;
    end else begin
      msgValid <= sendReq;
    end
  end
  // ==========================================================
  // Attributes mean nothing without the strobe, so they toggle then
  always_ff @(posedge clock) begin
    if (sendReq) begin
      {msgError, msgExtended, msgRemote, msgFilter} <= sendAttr;
    end else begin
      {msgError, msgExtended, msgRemote, msgFilter} <=
        ~{msgError, msgExtended, msgRemote, msgFilter};
    end
  end
endmodule : can_engine_model
`default_nettype wire

// ===== testbench/tb_can_rx_buffer1_control.sv
// Self-checking testbench of the receive buffer 1 control block
`timescale 1ns/1ns
`default_nettype none
`include "can_rx_consts.svh"

module tb_can_rx_buffer1_control;
  import can_rx_pkg::*;
  logic clock = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, sendReq = 1'b0, dbe = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic [5:0] sendAttr = 6'h0;
  logic pready, pslverr, mV, mE, mX, mR, msgLoad, full, irq, err, ld;
  filter_index_type mF;
  accept_mode_type mode;
  int bad_count = 0, compares = 0;

  can_engine_model eng (.clock(clock), .rst(rst), .sendReq(sendReq),
    .sendAttr(sendAttr), .msgValid(mV), .msgError(mE),
    .msgExtended(mX), .msgRemote(mR), .msgFilter(mF));
  can_rx_buffer1_control DUT (.clock(clock), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .msgValid(mV),
    .msgError(mE), .msgExtended(mX), .msgRemote(mR), .msgFilter(mF),
    .doubleBufferEnable(dbe), .msgLoad(msgLoad),
    .rxBufferFullFlag(full), .rxAcceptMode(mode), .irq(irq));

  // ==========================================================
  // Common tasks
  task stop_test;
    if (bad_count == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : stop_test

  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task offer(input logic [5:0] attr, input logic db);
    @(posedge clock);
    sendReq <= 1'b1;
    sendAttr <= attr;
    dbe <= db;
    @(posedge clock);
    sendReq <= 1'b0;
    #1 ld = msgLoad;
  endtask : offer

  // ==========================================================
  // Scenarios
  task t_reset;
    apb(1'b0, `CRX_OFF_CTRL, 32'h0);
    chk(q, `CRX_CTRL_RESET);
    chk(err, 1'b0);
    apb(1'b0, `CRX_OFF_STATUS, 32'h0);
    chk(q, 32'h0);
    apb(1'b0, `CRX_OFF_ENABLE, 32'h0);
    chk(q, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    chk(q, 32'h0);
    chk(err, 1'b1);
    chk(irq, 1'b0);
  endtask : t_reset

  task t_modes;
    logic e;
    for (int m = 0; m < 4; m++) begin
      for (int c = 0; c < 4; c++) begin
        apb(1'b1, `CRX_OFF_CTRL, m << 5);
        e = (m == 3) || (c < 2 && (m == 0 || (m == 1) == (c == 0)));
        offer({c[1:0], 4'h2}, 1'b0);
        chk(mode, m);
        chk(ld, e);
        apb(1'b0, `CRX_OFF_CTRL, 32'h0);
        chk(q[7], e);
        chk(full, e);
      end
    end
  endtask : t_modes

  task t_filters;
    apb(1'b1, `CRX_OFF_CTRL, 32'h60);
    offer(6'h0d, 1'b0);
    chk(ld, 1'b1);
    apb(1'b0, `CRX_OFF_CTRL, 32'h0);
    chk(q, 32'hed);
    offer(6'h03, 1'b1);
    chk(ld, 1'b0);
    apb(1'b0, `CRX_OFF_CTRL, 32'h0);
    chk(q, 32'hed);
    apb(1'b0, `CRX_OFF_STATUS, 32'h0);
    chk(q, 32'h3);
    apb(1'b1, `CRX_OFF_CTRL, 32'h60);
    offer(6'h00, 1'b0);
    chk(ld, 1'b0);
    offer(6'h06, 1'b1);
    chk(ld, 1'b0);
    offer(6'h07, 1'b1);
    chk(ld, 1'b0);
    offer(6'h01, 1'b1);
    chk(ld, 1'b1);
    apb(1'b0, `CRX_OFF_CTRL, 32'h0);
    chk(q, 32'he1);
    apb(1'b1, `CRX_OFF_CTRL, 32'h70);
    apb(1'b1, `CRX_OFF_CTRL, 32'hf0);
    apb(1'b0, `CRX_OFF_CTRL, 32'h0);
    chk(q, 32'h61);
  endtask : t_filters

  task t_irq;
    apb(1'b1, `CRX_OFF_CLEAR, 32'h3);
    apb(1'b1, `CRX_OFF_ENABLE, 32'h1);
    apb(1'b0, `CRX_OFF_ENABLE, 32'h0);
    chk(q, 32'h1);
    offer(6'h04, 1'b0);
    repeat (2) @(posedge clock);
    #1 chk(irq, 1'b1);
    apb(1'b1, `CRX_OFF_CLEAR, 32'h1);
    apb(1'b0, `CRX_OFF_STATUS, 32'h0);
    chk(q, 32'h0);
    chk(irq, 1'b0);
    apb(1'b1, `CRX_OFF_ENABLE, 32'h0);
    apb(1'b1, `CRX_OFF_CTRL, 32'h60);
    offer(6'h05, 1'b0);
    apb(1'b0, `CRX_OFF_STATUS, 32'h0);
    chk(q, 32'h1);
    chk(irq, 1'b0);
    // Status is read-only and the clear register reads zero
    apb(1'b1, `CRX_OFF_STATUS, 32'h0);
    apb(1'b0, `CRX_OFF_STATUS, 32'h0);
    chk(q, 32'h1);
    chk(err, 1'b0);
    apb(1'b0, `CRX_OFF_CLEAR, 32'h0);
    chk(q, 32'h0);
  endtask : t_irq

  task t_midreset;
    apb(1'b1, `CRX_OFF_ENABLE, 32'h1);
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    apb(1'b0, `CRX_OFF_CTRL, 32'h0);
    chk(q, `CRX_CTRL_RESET);
    chk(mode, MODE_VALID_ALL);
    apb(1'b0, `CRX_OFF_STATUS, 32'h0);
    chk(q, 32'h0);
    chk(irq, 1'b0);
  endtask : t_midreset

  // ==========================================================
  // Clock, watchdog and main sequence
  initial begin
    forever #5 clock = ~clock;
  end

  initial begin
    #200000;
    bad_count++;
    stop_test;
  end

  initial begin
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    t_reset;
    t_modes;
    t_filters;
    t_irq;
    t_midreset;
    stop_test;
  end
endmodule : tb_can_rx_buffer1_control
`default_nettype wire
